// >>> core/rpm_pkg.sv
package rpm_pkg;

    // Special function register addresses.
    localparam logic [7:0] POWER_MODE_CONTROL_ADDR     = 8'h87;
    localparam logic [7:0] RESET_CAUSE_REGISTER_ADDR   = 8'hEF;
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hFF;

    // Field positions of the power mode control register.
    localparam int PMC_IDLE_BIT    = 0;
    localparam int PMC_STOP_BIT    = 1;
    localparam int PMC_SCRATCH_LSB = 2;
    localparam int PMC_SCRATCH_MSB = 7;

    // Field positions of the reset cause register.
    localparam int RC_PIN_BIT      = 0;
    localparam int RC_POWER_ON_BIT = 1;
    localparam int RC_MCD_BIT      = 2;
    localparam int RC_WDT_BIT      = 3;
    localparam int RC_SW_BIT       = 4;
    localparam int RC_CMP_BIT      = 5;
    localparam int RC_MEMERR_BIT   = 6;

    // Field positions of the supply monitor control register.
    localparam int SMC_ENABLE_BIT = 7;
    localparam int SMC_STATUS_BIT = 6;

    // Reset values.
    localparam logic [5:0]  SCRATCH_RESET      = 6'h00;
    localparam logic [6:0]  CAUSE_FLAGS_RESET  = 7'h00;
    localparam logic [7:0]  PORT_LATCH_RESET   = 8'hFF;
    localparam logic [15:0] FETCH_START_ADDR   = 16'h0000;
    localparam logic [7:0]  READ_ZERO          = 8'h00;
    localparam logic [2:0]  SYNC_RESET_VALUE   = 3'h3;

    // Timing: 100 MHz system clock and the power-on release delay.
    localparam real CLK_PERIOD_NS              = 10.0;
    localparam real POWER_ON_RELEASE_DELAY_MS  = 0.3;
    localparam int  POWER_ON_RELEASE_CYCLES    =
        int'($floor(POWER_ON_RELEASE_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int  DELAY_CNT_W                = 16;
    localparam logic [DELAY_CNT_W-1:0] PIN_SETTLE_CYCLES = 16'h0003;

    // Watchdog prescaler divides the system clock by twelve.
    localparam int         WDT_CNT_W  = 4;
    localparam logic [3:0] WDT_DIVIDE = 4'hC;

    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY, ST_SETTLE} seq_state_t;

    typedef enum logic [2:0] {
        CAUSE_POWER, CAUSE_SUPPLY, CAUSE_PIN, CAUSE_MCD,
        CAUSE_WDT, CAUSE_SW, CAUSE_CMP, CAUSE_MEMERR
    } cause_t;

endpackage

// >>> core/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop
    import rpm_pkg::*;
#(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    // The first stage is read only by the second, to let metastability settle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            stage1_q <= RESET_VAL;
            syncOut  <= RESET_VAL;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule

// >>> core/reset_and_power_mode_control.sv
// What this block does
// - Bits 7:2 are plain software scratch flags.
// - Writing stop bit halts oscillator, reads 0.
// - Writing idle bit gates CPU clock only.
// - Reset halts core, initialises registers, ports, timers.
// - Data memory survives reset; stack pointer reinitialised.
// - Port latches load ones; weak pull-ups stay on.
// - Power and supply resets drive pin low.
// - Exit clears PC, internal oscillator, fetch 0x0000.
// - Watchdog enabled, clocked at system clock/12.
// - Power-on waits extra release delay after threshold.
// - Power or supply reset exit sets power flag.
// - Any other reset clears the power flag.
// - Monitor enabled by power-on only, else kept.
// - Low supply holds reset until supply recovers.
// - Supply reset release skips the power-on delay.
// - Enabled interrupt or reset ends idle mode.
// - Only a reset ends stop mode.
// - Monitor resets only when enabled and selected.
`timescale 1ns/1ps
module reset_and_power_mode_control
    import rpm_pkg::*;
#(
    parameter int PorDelayCycles = POWER_ON_RELEASE_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic [7:0]  sfrWrData,
    input  wire logic        sfrRdEn,
    output logic      [7:0]  sfrRdData,
    input  wire logic        powerOnDetect,
    input  wire logic        supplyAboveThreshold,
    input  wire logic        resetPinIn,
    output logic             resetPinOut,
    output logic             resetPinOe,
    input  wire logic        mcdTimeout,
    input  wire logic        watchdogExpire,
    input  wire logic        comparatorTrip,
    input  wire logic        memoryError,
    input  wire logic        enabledInterrupt,
    input  wire logic        watchdogDisable,
    input  wire logic        selectExternalClock,
    output logic             coreResetN,
    output logic             peripheralResetN,
    output logic             cpuClockEnable,
    output logic             internalOscEnable,
    output logic             fetchStart,
    output logic      [15:0] fetchAddress,
    output logic             sysClkSelInternal,
    output logic             watchdogEnable,
    output logic             watchdogTick,
    output logic             portLatchLoad,
    output logic      [7:0]  portLatchValue,
    output logic             weakPullupEnable,
    output logic             supplyMonitorEnable
);

    seq_state_t             state_q;
    seq_state_t             state_d;
    cause_t                 cause_q;
    cause_t                 cause_d;
    cause_t                 reqCause;
    logic [DELAY_CNT_W-1:0] cnt_q;
    logic [WDT_CNT_W-1:0]   wdtCnt_q;
    logic [5:0]             scratch_q;
    logic [6:0]             flags_q;
    logic                   idle_q;
    logic                   stop_q;
    logic                   monSelect_q;
    logic                   mcdEnable_q;
    logic                   cmpSelect_q;
    logic                   swReq_q;
    logic [2:0]             syncVec;

    // Pins and the analog comparator are asynchronous to clk.
    sync_two_flop #(
        .WIDTH     (3),
        .RESET_VAL (SYNC_RESET_VALUE)
    ) u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .asyncIn ({powerOnDetect, supplyAboveThreshold, resetPinIn}),
        .syncOut (syncVec)
    );

    wire porSync    = syncVec[2];
    wire supplyOk   = syncVec[1];
    wire pinHigh    = syncVec[0];

    // Register decode; writes are ignored while the core is held in reset.
    wire pmcSel     = (sfrAddr == POWER_MODE_CONTROL_ADDR);
    wire rcSel      = (sfrAddr == RESET_CAUSE_REGISTER_ADDR);
    wire smcSel     = (sfrAddr == SUPPLY_MONITOR_CONTROL_ADDR);
    wire wrOk       = sfrWrEn & coreResetN;
    wire pmcWr      = wrOk & pmcSel;
    wire rcWr       = wrOk & rcSel;
    wire smcWr      = wrOk & smcSel;

    // While the pin is driven low by this block, or just released, its
    // synchronised image still reads low; masking it avoids a false pin reset.
    wire pinMask    = resetPinOe | (state_q == ST_SETTLE);

    wire monReq     = ~supplyOk & supplyMonitorEnable & monSelect_q;
    wire pinReq     = ~pinHigh & ~pinMask;
    wire mcdReq     = mcdTimeout & mcdEnable_q;
    wire cmpReq     = comparatorTrip & cmpSelect_q;
    wire wdtReq     = watchdogExpire & watchdogEnable;
    wire anyReq     = porSync | monReq | pinReq | mcdReq | cmpReq | wdtReq
                    | memoryError | swReq_q;

    // Highest-priority cause among the requests active now.
    assign reqCause = porSync     ? CAUSE_POWER  :
                      monReq      ? CAUSE_SUPPLY :
                      pinReq      ? CAUSE_PIN    :
                      mcdReq      ? CAUSE_MCD    :
                      wdtReq      ? CAUSE_WDT    :
                      swReq_q     ? CAUSE_SW     :
                      cmpReq      ? CAUSE_CMP    : CAUSE_MEMERR;

    wire powerCause = (cause_d == CAUSE_POWER) | (cause_d == CAUSE_SUPPLY);
    wire delayDone  = (cnt_q == DELAY_CNT_W'(PorDelayCycles - 1));
    wire settleDone = (cnt_q == PIN_SETTLE_CYCLES - 16'h0001);
    wire inReset_d  = (state_d != ST_RUN);
    wire exitPulse  = inReset_d ? 1'b0 : (state_q != ST_RUN);

    // Reset sequencer: hold while any request stands, then delay or settle.
    always_comb
    begin
        state_d = state_q;
        cause_d = cause_q;
        case (state_q)
            ST_RUN:
            begin
                if (anyReq)
                begin
                    state_d = ST_HOLD;
                    cause_d = reqCause;
                end
            end
            ST_HOLD:
            begin
                if (porSync)
                    cause_d = CAUSE_POWER;
                else if (monReq && cause_q != CAUSE_POWER)
                    cause_d = CAUSE_SUPPLY;
                if (!anyReq)
                begin
                    if (cause_q == CAUSE_POWER)
                        state_d = ST_DELAY;
                    else
                        state_d = ST_SETTLE;
                end
            end
            ST_DELAY:
            begin
                if (anyReq)
                begin
                    state_d = ST_HOLD;
                    cause_d = reqCause;
                end
                else if (delayDone)
                    state_d = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                if (anyReq)
                begin
                    state_d = ST_HOLD;
                    cause_d = reqCause;
                end
                else if (settleDone)
                    state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_HOLD;
                cause_d = CAUSE_POWER;
            end
        endcase
    end

    // The digital reset is treated as a power-on: sequence starts in hold.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= ST_HOLD;
            cause_q <= CAUSE_POWER;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cause_q <= cause_d;
            cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            resetPinOut <= 1'b0;
            resetPinOe  <= 1'b1;
        end
        else
        begin
            resetPinOut <= 1'b0;
            resetPinOe  <= powerCause & ((state_d == ST_HOLD) | (state_d == ST_DELAY));
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            coreResetN       <= 1'b0;
            peripheralResetN <= 1'b0;
            fetchStart       <= 1'b0;
            fetchAddress     <= FETCH_START_ADDR;
        end
        else
        begin
            coreResetN       <= ~inReset_d;
            peripheralResetN <= ~inReset_d;
            fetchStart       <= exitPulse;
            fetchAddress     <= FETCH_START_ADDR;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            portLatchLoad    <= 1'b1;
            portLatchValue   <= PORT_LATCH_RESET;
            weakPullupEnable <= 1'b1;
        end
        else
        begin
            portLatchLoad    <= inReset_d;
            portLatchValue   <= PORT_LATCH_RESET;
            weakPullupEnable <= 1'b1;
        end
    end

    // Idle clears on an interrupt, but a write setting it in the same cycle wins.
    wire idle_d = inReset_d ? 1'b0 :
                  (pmcWr & sfrWrData[PMC_IDLE_BIT]) ? 1'b1 :
                  enabledInterrupt ? 1'b0 : idle_q;
    // Stop ignores interrupts entirely; only the sequencer clears it.
    wire stop_d = inReset_d ? 1'b0 :
                  (pmcWr & sfrWrData[PMC_STOP_BIT]) ? 1'b1 : stop_q;

    // Power modes and scratch flags.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            scratch_q         <= SCRATCH_RESET;
            idle_q            <= 1'b0;
            stop_q            <= 1'b0;
            cpuClockEnable    <= 1'b1;
            internalOscEnable <= 1'b1;
        end
        else
        begin
            if (pmcWr)
                scratch_q <= sfrWrData[PMC_SCRATCH_MSB:PMC_SCRATCH_LSB];
            else if (inReset_d)
                scratch_q <= SCRATCH_RESET;
            idle_q            <= idle_d;
            stop_q            <= stop_d;
            cpuClockEnable    <= ~(idle_d | stop_d);
            internalOscEnable <= ~stop_d;
        end
    end

    // Reset cause flags, source selects and the software reset strobe.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            flags_q             <= CAUSE_FLAGS_RESET;
            monSelect_q         <= 1'b0;
            mcdEnable_q         <= 1'b0;
            cmpSelect_q         <= 1'b0;
            swReq_q             <= 1'b0;
            supplyMonitorEnable <= 1'b1;
        end
        else
        begin
            swReq_q <= rcWr & sfrWrData[RC_SW_BIT];
            if (rcWr)
            begin
                monSelect_q <= sfrWrData[RC_POWER_ON_BIT];
                mcdEnable_q <= sfrWrData[RC_MCD_BIT];
                cmpSelect_q <= sfrWrData[RC_CMP_BIT];
            end
            else if (exitPulse && cause_q == CAUSE_POWER)
                monSelect_q <= 1'b1;
            if (smcWr)
                supplyMonitorEnable <= sfrWrData[SMC_ENABLE_BIT];
            else if (exitPulse && cause_q == CAUSE_POWER)
                supplyMonitorEnable <= 1'b1;
            if (exitPulse)
            begin
                if (cause_q == CAUSE_POWER || cause_q == CAUSE_SUPPLY)
                    flags_q[RC_POWER_ON_BIT] <= 1'b1;
                else
                begin
                    flags_q                  <= CAUSE_FLAGS_RESET;
                    flags_q[RC_PIN_BIT]      <= (cause_q == CAUSE_PIN);
                    flags_q[RC_MCD_BIT]      <= (cause_q == CAUSE_MCD);
                    flags_q[RC_WDT_BIT]      <= (cause_q == CAUSE_WDT);
                    flags_q[RC_SW_BIT]       <= (cause_q == CAUSE_SW);
                    flags_q[RC_CMP_BIT]      <= (cause_q == CAUSE_CMP);
                    flags_q[RC_MEMERR_BIT]   <= (cause_q == CAUSE_MEMERR);
                end
            end
        end
    end

    // watchdog enable and divide by twelve
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            watchdogEnable    <= 1'b1;
            wdtCnt_q          <= '0;
            watchdogTick      <= 1'b0;
            sysClkSelInternal <= 1'b1;
        end
        else
        begin
            watchdogEnable <= inReset_d ? 1'b1 : (watchdogEnable & ~watchdogDisable);
            if (inReset_d || wdtCnt_q == WDT_DIVIDE - 4'h1)
                wdtCnt_q <= '0;
            else if (internalOscEnable)
                wdtCnt_q <= wdtCnt_q + 4'h1;
            watchdogTick <= ~inReset_d & internalOscEnable
                          & (wdtCnt_q == WDT_DIVIDE - 4'h1);
            sysClkSelInternal <= inReset_d ? 1'b1
                               : (sysClkSelInternal & ~selectExternalClock);
        end
    end

    // Read multiplexer; stop and idle bits always read zero.
    wire [7:0] pmcRead = {scratch_q, 2'b00};
    wire [7:0] rcRead  = {1'b0, flags_q};
    wire [7:0] smcRead = {supplyMonitorEnable, supplyOk, 6'h00};
    wire [7:0] rdMux   = pmcSel ? pmcRead :
                         rcSel  ? rcRead  :
                         smcSel ? smcRead : READ_ZERO;

    // Read data is registered one cycle after the read strobe.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            sfrRdData <= READ_ZERO;
        else if (sfrRdEn)
            sfrRdData <= rdMux;
    end

endmodule

// >>> tb/reset_and_power_mode_control_chk.sv
`timescale 1ns/1ps
module reset_and_power_mode_control_chk
    import rpm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  sfrAddr,
    input wire logic        sfrWrEn,
    input wire logic [7:0]  sfrWrData,
    input wire logic        memoryError,
    input wire logic        enabledInterrupt,
    input wire logic        resetPinOut,
    input wire logic        resetPinOe,
    input wire logic        coreResetN,
    input wire logic        cpuClockEnable,
    input wire logic        internalOscEnable,
    input wire logic        fetchStart,
    input wire logic [15:0] fetchAddress,
    input wire logic        sysClkSelInternal,
    input wire logic        watchdogEnable,
    input wire logic        watchdogTick,
    input wire logic        portLatchLoad,
    input wire logic [7:0]  portLatchValue,
    input wire logic        weakPullupEnable
);
    // Only writes taken while the core runs can change the power mode.
    wire logic pmcWr = coreResetN && sfrWrEn && (sfrAddr == POWER_MODE_CONTROL_ADDR);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_fetch_on_rise: assert property ($rose(coreResetN) |-> fetchStart)
        else $error("fetch pulse missing at reset release");
    a_fetch_only_rise: assert property (
        fetchStart |-> coreResetN && !$past(coreResetN))
        else $error("fetch pulse away from reset release");
    a_exit_defaults: assert property ($rose(coreResetN) |->
        sysClkSelInternal && watchdogEnable && fetchAddress == FETCH_START_ADDR)
        else $error("wrong clock, watchdog or fetch address at release");
    a_port_state: assert property (!coreResetN |-> portLatchLoad && weakPullupEnable
        && portLatchValue == PORT_LATCH_RESET && !resetPinOut)
        else $error("port latches not forced during reset");
    a_pin_in_reset: assert property (resetPinOe |-> !coreResetN)
        else $error("reset pin driven while core runs");
    a_idle_entry: assert property (
        pmcWr && sfrWrData[PMC_IDLE_BIT] |=> !cpuClockEnable)
        else $error("idle write did not gate the cpu clock");
    a_stop_entry: assert property (pmcWr && sfrWrData[PMC_STOP_BIT]
        |=> !internalOscEnable && !cpuClockEnable)
        else $error("stop write did not halt the oscillator");
    a_idle_wake: assert property (coreResetN && internalOscEnable && !cpuClockEnable
        && enabledInterrupt && !pmcWr |=> cpuClockEnable)
        else $error("interrupt did not end idle");
    a_stop_stays: assert property (coreResetN && !internalOscEnable
        |=> !internalOscEnable || !coreResetN)
        else $error("stop left without a reset");
    a_wdt_spacing: assert property (
        watchdogTick |=> (!watchdogTick)[*8] ##1 (!watchdogTick)[*3])
        else $error("watchdog ticks closer than twelve clocks");
    a_memerr_reset: assert property (
        coreResetN && memoryError |-> ##[1:2] !coreResetN)
        else $error("request did not reset the core");

    c_idle: cover property (pmcWr && sfrWrData[PMC_IDLE_BIT]);
    c_stop: cover property (coreResetN && !internalOscEnable);
    c_pin_drive: cover property (resetPinOe);
    c_release: cover property (fetchStart);
endmodule

// >>> tb/sfr_core_model.sv
`timescale 1ns/1ps
module sfr_core_model
(
    input  wire logic       clk,
    input  wire logic [7:0] sfrRdData,
    output logic      [7:0] sfrAddr,
    output logic            sfrWrEn,
    output logic      [7:0] sfrWrData,
    output logic            sfrRdEn
);
    // Idle bus at time zero; released lines show the inverse of the last value.
    initial
    begin
        sfrAddr   = 8'h00;
        sfrWrEn   = 1'b0;
        sfrWrData = 8'h00;
        sfrRdEn   = 1'b0;
    end

    // One write, taken at the rising edge between two falling edges.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrAddr   = a;
        sfrWrData = d;
        sfrWrEn   = 1'b1;
        @(negedge clk);
        sfrWrEn   = 1'b0;
        sfrAddr   = ~a;
        sfrWrData = ~d;
    endtask

    // One read; the data lands at the taking edge and is sampled one edge later.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge clk);
        sfrRdEn = 1'b0;
        sfrAddr = ~a;
        @(posedge clk);
        #1 q = sfrRdData;
    endtask
endmodule

// >>> tb/test_reset_and_power_mode_control.sv
`timescale 1ns/1ps
module test_reset_and_power_mode_control
    import rpm_pkg::*;
;
    localparam int POR = 20;
    logic clk = 1'b0, rstn = 1'b0, powerOnDetect = 1'b0, supplyAboveThreshold = 1'b1;
    logic memoryError = 1'b0, enabledInterrupt = 1'b0, watchdogDisable = 1'b0, extPinLow = 1'b0;
    logic selectExternalClock = 1'b0, resetPinOut, resetPinOe, coreResetN, cpuClockEnable;
    logic internalOscEnable, fetchStart, sysClkSelInternal, watchdogEnable, watchdogTick;
    logic portLatchLoad, weakPullupEnable, supplyMonitorEnable, sfrWrEn, sfrRdEn, sfrResetN;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, portLatchValue, q, v;
    logic [15:0] fetchAddress;
    int mismatches = 0, total_checks = 0, cycles = 0, n;
    // Open-drain reset pin with its pull-up; extPinLow is an outside switch to ground.
    wire logic resetPinIn = resetPinOe ? resetPinOut : ~extPinLow;

    always #5 clk = ~clk;

    reset_and_power_mode_control #(.PorDelayCycles(POR)) DUT (
        .clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .powerOnDetect(powerOnDetect),
        .supplyAboveThreshold(supplyAboveThreshold), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .mcdTimeout(1'b0),
        .watchdogExpire(1'b0), .comparatorTrip(1'b0), .memoryError(memoryError),
        .enabledInterrupt(enabledInterrupt), .watchdogDisable(watchdogDisable),
        .selectExternalClock(selectExternalClock), .coreResetN(coreResetN),
        .peripheralResetN(sfrResetN), .cpuClockEnable(cpuClockEnable),
        .internalOscEnable(internalOscEnable), .fetchStart(fetchStart),
        .fetchAddress(fetchAddress), .sysClkSelInternal(sysClkSelInternal),
        .watchdogEnable(watchdogEnable), .watchdogTick(watchdogTick),
        .portLatchLoad(portLatchLoad), .portLatchValue(portLatchValue),
        .weakPullupEnable(weakPullupEnable), .supplyMonitorEnable(supplyMonitorEnable));

    sfr_core_model core (.clk(clk), .sfrRdData(sfrRdData), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts edges until the release pulse; a bounded wait so a stuck reset fails.
    task automatic runWait(output int c);
        c = 0;
        while (c < 200 && fetchStart !== 1'b1)
        begin
            @(posedge clk);
            #1 c++;
        end
        chk(fetchStart, 1'b1);
    endtask

    task automatic waitLow();
        repeat (20) if (coreResetN !== 1'b0) @(posedge clk);
        #1 chk(coreResetN, 1'b0);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial
    begin
        void'($urandom(52102));
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        runWait(n);
        chk(n >= POR, 1'b1);
        core.rd(POWER_MODE_CONTROL_ADDR, q); chk(q, 8'h00);
        core.rd(RESET_CAUSE_REGISTER_ADDR, q); chk(q, 8'h02);
        core.rd(SUPPLY_MONITOR_CONTROL_ADDR, q); chk(q, 8'hC0);
        core.rd(8'h80, q); chk(q, 8'h00);
        // Any 24 running cycles hold exactly two watchdog ticks.
        n = 0;
        repeat (24) @(negedge clk) n += watchdogTick;
        chk(16'(n), 16'h0002);
        $display("test 1 done");
        // Scratch flags keep random values; the mode bits stay clear.
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 8'hFC : 8'($urandom) & 8'hFC;
            core.wr(POWER_MODE_CONTROL_ADDR, v);
            core.rd(POWER_MODE_CONTROL_ADDR, q); chk(q, v);
        end
        $display("test 2 done");
        core.wr(POWER_MODE_CONTROL_ADDR, v | 8'h01);
        chk({cpuClockEnable, internalOscEnable}, 2'b01);
        core.rd(POWER_MODE_CONTROL_ADDR, q); chk(q, v);
        pulse(enabledInterrupt);
        chk(cpuClockEnable, 1'b1);
        $display("test 3 done");
        core.wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h00);
        core.wr(RESET_CAUSE_REGISTER_ADDR, 8'h10);
        waitLow();
        chk({portLatchLoad, resetPinOe, sfrResetN, supplyMonitorEnable}, 4'h8);
        runWait(n);
        core.rd(RESET_CAUSE_REGISTER_ADDR, q); chk(q, 8'h10);
        core.rd(POWER_MODE_CONTROL_ADDR, q); chk(q, 8'h00);
        core.rd(SUPPLY_MONITOR_CONTROL_ADDR, q); chk(q, 8'h40);
        $display("test 4 done");
        // Enable first, then select the monitor as a reset source.
        // enable before select
        core.wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h80);
        core.wr(RESET_CAUSE_REGISTER_ADDR, 8'h02);
        @(negedge clk) supplyAboveThreshold = 1'b0;
        waitLow();
        repeat (2) @(posedge clk);
        #1 chk(resetPinOe, 1'b1);
        @(negedge clk) supplyAboveThreshold = 1'b1;
        runWait(n);
        chk(n < POR, 1'b1);
        core.rd(RESET_CAUSE_REGISTER_ADDR, q); chk(q[RC_POWER_ON_BIT], 1'b1);
        $display("test 5 done");
        core.wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h00);
        // A low supply with the monitor switched off must not reset the core.
        @(negedge clk) supplyAboveThreshold = 1'b0;
        repeat (4) @(negedge clk);
        chk(coreResetN, 1'b1);
        supplyAboveThreshold = 1'b1;
        pulse(selectExternalClock);
        pulse(watchdogDisable);
        chk({sysClkSelInternal, watchdogEnable}, 2'b00);
        core.wr(POWER_MODE_CONTROL_ADDR, 8'h02);
        pulse(enabledInterrupt);
        chk({cpuClockEnable, internalOscEnable}, 2'b00);
        core.rd(POWER_MODE_CONTROL_ADDR, q); chk(q, 8'h00);
        pulse(memoryError);
        waitLow();
        runWait(n);
        chk({sysClkSelInternal, watchdogEnable, internalOscEnable}, 3'b111);
        core.rd(RESET_CAUSE_REGISTER_ADDR, q); chk(q, 8'h40);
        core.rd(SUPPLY_MONITOR_CONTROL_ADDR, q); chk(q, 8'h40);
        $display("test 6 done");
        // An outside pin reset is not driven back onto the pin.
        pulse(extPinLow);
        waitLow();
        chk(resetPinOe, 1'b0);
        runWait(n);
        core.rd(RESET_CAUSE_REGISTER_ADDR, q); chk(q, 8'h01);
        $display("test 7 done");
        @(negedge clk) powerOnDetect = 1'b1;
        waitLow();
        repeat (3) @(posedge clk);
        #1 chk(resetPinOe, 1'b1);
        @(negedge clk) powerOnDetect = 1'b0;
        runWait(n);
        chk(n >= POR, 1'b1);
        core.rd(SUPPLY_MONITOR_CONTROL_ADDR, q); chk(q, 8'hC0);
        $display("test 8 done");
        tally_and_finish();
    end
endmodule

bind reset_and_power_mode_control reset_and_power_mode_control_chk chk (
    .clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .memoryError(memoryError), .enabledInterrupt(enabledInterrupt),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .coreResetN(coreResetN),
    .cpuClockEnable(cpuClockEnable), .internalOscEnable(internalOscEnable),
    .fetchStart(fetchStart), .fetchAddress(fetchAddress),
    .sysClkSelInternal(sysClkSelInternal), .watchdogEnable(watchdogEnable),
    .watchdogTick(watchdogTick), .portLatchLoad(portLatchLoad),
    .portLatchValue(portLatchValue), .weakPullupEnable(weakPullupEnable));
